/* rtl/dioc_pkg.sv */
// Constants shared by the discrete input/output conditioner
package dioc_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_FREQ_HZ  = 20_000_000;
   localparam int TICK_TIME_MS = 1;
   localparam int TICK_CYCLES  = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
   localparam int TIME_MAX_MS  = 10000;
   localparam int TIME_W       = 14;

   // ****************************************************************
   // Channel layout
   // ****************************************************************
   localparam int AUX_PORTS    = 8;
   localparam int PIN_COUNT    = 4;
   localparam int CHANNELS     = AUX_PORTS + PIN_COUNT;
   localparam int PIN_TWO_IDX  = 1;
   localparam int PIN_FOUR_IDX = 3;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_OUT_IMAGE  = 8'h04;
   localparam logic [7:0]  OFS_IN_IMAGE   = 8'h08;
   localparam logic [7:0]  OFS_AUX_STATUS = 8'h0C;
   localparam logic [7:0]  OFS_AUX_CFG    = 8'h10;
   localparam logic [7:0]  OFS_PIN_CFG    = 8'h14;
   localparam logic [7:0]  OFS_AUX_TIME   = 8'h20;
   localparam logic [7:0]  OFS_PIN_TIME   = 8'h40;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_ACTIVE_BIT  = 0;
   localparam int AUX_INV_LSB      = 8;
   localparam int PIN_INV_LSB      = 8;
   localparam int PIN_DEF_TWO_BIT  = 12;
   localparam int PIN_DEF_FOUR_BIT = 13;
   localparam int TIME_HOLD_LSB    = 16;

   // ****************************************************************
   // Pin modes and reset values
   // ****************************************************************
   localparam logic [1:0]        MODE_OFF    = 2'h0;
   localparam logic [1:0]        MODE_INPUT  = 2'h1;
   localparam logic [1:0]        MODE_OUTPUT = 2'h2;
   localparam logic [7:0]        RST_AUX_EN  = 8'h00;
   localparam logic [7:0]        RST_AUX_INV = 8'h00;
   localparam logic [3:0]        RST_PIN_INV = 4'h0;
   localparam logic              RST_DEF_LVL = 1'b0;
   localparam logic [TIME_W-1:0] RST_TIME    = 14'h0000;

   typedef enum logic {BUS_IDLE, BUS_ANSWER} dioc_bus_state_type;

endpackage

/* rtl/dioc_filt_if.sv */
// Carrier between the conditioner and one settling/hold filter
`timescale 1ns/1ps
`default_nettype none
interface dioc_filt_if;
   import dioc_pkg::*;
   logic              raw;
   logic              clear;
   logic              tick;
   logic [TIME_W-1:0] settle;
   logic [TIME_W-1:0] hold;
   logic              level;
   modport ctrl (output raw, output clear, output tick, output settle, output hold, input level);
   modport filt (input raw, input clear, input tick, input settle, input hold, output level);
endinterface
`default_nettype wire

/* rtl/dioc_filter.sv */
// Settling acceptance followed by high-level hold stretching for one input
`timescale 1ns/1ps
`default_nettype none
module dioc_filter
   import dioc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Filter channel
   dioc_filt_if.filt f
);

   logic [TIME_W-1:0] settle_cnt;
   logic [TIME_W-1:0] hold_cnt;
   logic              accepted;
   logic              settle_done;
   logic              rise;

   assign settle_done = (f.settle == '0) || (f.tick && ((settle_cnt + 1'b1) >= f.settle));
   assign rise        = f.raw && !accepted && settle_done;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         accepted   <= 1'b0;
         settle_cnt <= '0;
      end else if (f.clear) begin
         settle_cnt <= '0;
      end else if (f.raw == accepted) begin
         settle_cnt <= '0;
      end else if (settle_done) begin
         accepted   <= f.raw;
         settle_cnt <= '0;
      end else if (f.tick) begin
         settle_cnt <= settle_cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt <= '0;
      end else if (f.clear) begin
         hold_cnt <= '0;
      end else if (rise) begin
         hold_cnt <= f.hold;
      end else if (f.tick && (hold_cnt != '0)) begin
         hold_cnt <= hold_cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         f.level <= 1'b0;
      end else begin
         f.level <= accepted || (hold_cnt != '0);
      end
   end

   settle_wait_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!f.clear && (f.settle != '0) && !f.tick && (f.raw != accepted)) |=> $stable(accepted))
      else $error("accepted level moved before the settling time ran out");

   settle_zero_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!f.clear && (f.settle == '0) && (f.raw != accepted)) |=> (accepted == $past(f.raw)))
      else $error("zero settling time did not accept at once");

   hold_stretch_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (rise && !f.clear && (f.hold != '0)) |=> ##1 f.level [*2])
      else $error("held high level was not reported");

   hold_load_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (rise && !f.clear) |=> (hold_cnt == $past(f.hold)))
      else $error("hold counter not loaded on a rising level");

endmodule
`default_nettype wire

/* rtl/dioc_top.sv */
// Discrete input/output conditioner with an Avalon-MM register slave
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Auxiliary input counts only when its enable bit is set; off after reset.
// - Auxiliary invert flips the input before filtering; off after reset.
// - Auxiliary level accepted only after holding steady for the settling time.
// - Auxiliary high reported for the hold time after detection; zero disables.
// - One input image byte and one output image byte for four pins.
// - Input image bits 0 to 3 carry pins one to four, 1 means high.
// - Input image bits 4 to 7 always read zero.
// - Only pins two and four drive; output image bits 1 and 3.
// - Each pin is off, input or output; input after reset.
// - Output mode is accepted only for pins two and four.
// - Output mode drives the default level or the controller value.
// - Pin invert flips reported input status in input mode and the driven output level.
// - Default level, low after reset, until written and after controller loss.
// - Pin input change reported after steady for settling time, 0 to 10000 ms.
// - Pin high held for the hold time up to 10000 ms; zero disables.
// - Output image bit one drives the pin high, zero drives it low.
// - Output image bits other than 1 and 3 reach no pin.
// - Conditioned auxiliary level sets its status byte bit high or low.
module dioc_top
   import dioc_pkg::*;
#(
   parameter int unsigned MS_CYCLES = TICK_CYCLES
)(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   // Field inputs
   input  wire logic [7:0]        aux_in,
   input  wire logic [3:0]        discrete_pin_in,
   // Output-capable pins
   output logic                   discrete_pin_two_o,
   output logic                   discrete_pin_two_oe,
   output logic                   discrete_pin_four_o,
   output logic                   discrete_pin_four_oe
);

   initial begin
      if (MS_CYCLES < 2) begin
         $error("MS_CYCLES must be at least 2");
      end
   end

   // ****************************************************************
   // Reset release and millisecond tick
   // ****************************************************************
   logic        rst_meta;
   logic        rst_n;
   logic [31:0] tick_cnt;
   logic        ms_tick;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         ms_tick  <= 1'b0;
      end else if (tick_cnt == 32'(MS_CYCLES - 1)) begin
         tick_cnt <= '0;
         ms_tick  <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         ms_tick  <= 1'b0;
      end
   end

   // ****************************************************************
   // Configuration and image registers
   // ****************************************************************
   dioc_bus_state_type bus_state;
   logic                    ctrl_active;
   logic                    out_written;
   logic [7:0]              out_image;
   logic [7:0]              aux_en;
   logic [7:0]              aux_inv;
   logic [1:0]              pin_mode [PIN_COUNT];
   logic [3:0]              pin_inv;
   logic                    def_two;
   logic                    def_four;
   logic [TIME_W-1:0]       settle [CHANNELS];
   logic [TIME_W-1:0]       hold [CHANNELS];
   logic                    cfg_clear;
   logic                    wr_go;
   logic                    cfg_wr;
   logic [31:0]             wmask;
   logic [31:0]             next_pin_cfg;
   logic [CHANNELS-1:0]     level;
   logic [7:0]              aux_raw;
   logic [3:0]              pin_raw;
   logic [7:0]              in_image;
   logic [7:0]              aux_status;

   function automatic logic [TIME_W-1:0] clamp_ms(input logic [15:0] v);
      if (v > 16'(TIME_MAX_MS)) begin
         return TIME_W'(TIME_MAX_MS);
      end
      return v[TIME_W-1:0];
   endfunction

   function automatic logic [1:0] pick_mode(input int idx, input logic [1:0] req,
                                            input logic [1:0] cur);
      if (req == MODE_OFF || req == MODE_INPUT) begin
         return req;
      end
      if (req == MODE_OUTPUT && (idx == PIN_TWO_IDX || idx == PIN_FOUR_IDX)) begin
         return req;
      end
      return cur;
   endfunction

   assign wr_go  = avs_write && (bus_state == BUS_ANSWER);
   assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign cfg_wr = wr_go && (avs_address == OFS_AUX_CFG || avs_address == OFS_PIN_CFG
                   || (avs_address >= OFS_AUX_TIME && avs_address < OFS_PIN_TIME + 8'h10));

   always_comb begin
      next_pin_cfg = 32'h0000_0000;
      for (int i = 0; i < PIN_COUNT; i++) begin
         next_pin_cfg[2*i +: 2] = pin_mode[i];
      end
      next_pin_cfg[PIN_INV_LSB +: 4]   = pin_inv;
      next_pin_cfg[PIN_DEF_TWO_BIT]    = def_two;
      next_pin_cfg[PIN_DEF_FOUR_BIT]   = def_four;
      next_pin_cfg = (next_pin_cfg & ~wmask) | (avs_writedata & wmask);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_active <= 1'b0;
         out_written <= 1'b0;
         out_image   <= 8'h00;
      end else begin
         if (wr_go && avs_address == OFS_CTRL && avs_byteenable[0]) begin
            ctrl_active <= avs_writedata[CTRL_ACTIVE_BIT];
         end
         if (wr_go && avs_address == OFS_OUT_IMAGE && avs_byteenable[0]) begin
            out_image   <= avs_writedata[7:0];
            out_written <= 1'b1;
         end else if (!ctrl_active) begin
            out_written <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_en  <= RST_AUX_EN;
         aux_inv <= RST_AUX_INV;
      end else if (wr_go && avs_address == OFS_AUX_CFG) begin
         if (avs_byteenable[0]) begin
            aux_en <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            aux_inv <= avs_writedata[AUX_INV_LSB +: 8];
         end
      end
   end

   // pin modes, invert and default levels
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PIN_COUNT; i++) begin
            pin_mode[i] <= MODE_INPUT;
         end
         pin_inv  <= RST_PIN_INV;
         def_two  <= RST_DEF_LVL;
         def_four <= RST_DEF_LVL;
      end else if (wr_go && avs_address == OFS_PIN_CFG) begin
         for (int i = 0; i < PIN_COUNT; i++) begin
            pin_mode[i] <= pick_mode(i, next_pin_cfg[2*i +: 2], pin_mode[i]);
         end
         pin_inv  <= next_pin_cfg[PIN_INV_LSB +: 4];
         def_two  <= next_pin_cfg[PIN_DEF_TWO_BIT];
         def_four <= next_pin_cfg[PIN_DEF_FOUR_BIT];
      end
   end

   // settling and hold times, clamped to the longest time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            settle[i] <= RST_TIME;
            hold[i]   <= RST_TIME;
         end
      end else if (wr_go) begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (avs_address == OFS_AUX_TIME + 8'(4 * i)) begin
               if (avs_byteenable[1:0] == 2'h3) begin
                  settle[i] <= clamp_ms(avs_writedata[15:0]);
               end
               if (avs_byteenable[3:2] == 2'h3) begin
                  hold[i] <= clamp_ms(avs_writedata[TIME_HOLD_LSB +: 16]);
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_clear <= 1'b1;
      end else begin
         cfg_clear <= cfg_wr;
      end
   end

   // ****************************************************************
   // Input conditioning
   // ****************************************************************
   // invert before filtering
   always_comb begin
      for (int i = 0; i < AUX_PORTS; i++) begin
         aux_raw[i] = aux_en[i] && (aux_in[i] ^ aux_inv[i]);
      end
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (pin_mode[i] == MODE_INPUT) begin
            pin_raw[i] = discrete_pin_in[i] ^ pin_inv[i];
         end else if (pin_mode[i] == MODE_OUTPUT) begin
            pin_raw[i] = discrete_pin_in[i];
         end else begin
            pin_raw[i] = 1'b0;
         end
      end
   end

   for (genvar g = 0; g < CHANNELS; g++) begin : gen_chan
      dioc_filt_if chan ();
      assign chan.raw    = (g < AUX_PORTS) ? aux_raw[g % AUX_PORTS] : pin_raw[g % PIN_COUNT];
      assign chan.clear  = cfg_clear;
      assign chan.tick   = ms_tick;
      assign chan.settle = settle[g];
      assign chan.hold   = hold[g];
      assign level[g]    = chan.level;
      dioc_filter u_filter (
         .sys_clk (sys_clk),
         .rst_n   (rst_n),
         .f       (chan.filt)
      );
   end

   // input image bits and auxiliary status
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_image   <= 8'h00;
         aux_status <= 8'h00;
      end else begin
         in_image   <= {4'h0, level[AUX_PORTS +: PIN_COUNT]};
         aux_status <= level[AUX_PORTS-1:0];
      end
   end

   // ****************************************************************
   // Output pins
   // ****************************************************************
   // pins two and four only
   // default or controller value, inverted, bits 1 and 3 only
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         discrete_pin_two_o   <= 1'b0;
         discrete_pin_four_o  <= 1'b0;
         discrete_pin_two_oe  <= 1'b0;
         discrete_pin_four_oe <= 1'b0;
      end else begin
         // output image bit to pin level
         discrete_pin_two_o   <= ((ctrl_active && out_written) ? out_image[PIN_TWO_IDX] : def_two)
                                 ^ pin_inv[PIN_TWO_IDX];
         discrete_pin_four_o  <= ((ctrl_active && out_written) ? out_image[PIN_FOUR_IDX]
                                 : def_four) ^ pin_inv[PIN_FOUR_IDX];
         discrete_pin_two_oe  <= (pin_mode[PIN_TWO_IDX] == MODE_OUTPUT);
         discrete_pin_four_oe <= (pin_mode[PIN_FOUR_IDX] == MODE_OUTPUT);
      end
   end

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************
   // image bytes mapped as registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state       <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state       <= BUS_ANSWER;
                  avs_waitrequest <= 1'b0;
                  avs_readdata    <= 32'h0000_0000;
                  if (avs_read) begin
                     if (avs_address == OFS_CTRL) begin
                        avs_readdata <= {31'h0000_0000, ctrl_active};
                     end else if (avs_address == OFS_OUT_IMAGE) begin
                        avs_readdata <= {24'h00_0000, out_image};
                     end else if (avs_address == OFS_IN_IMAGE) begin
                        avs_readdata <= {24'h00_0000, in_image};
                     end else if (avs_address == OFS_AUX_STATUS) begin
                        avs_readdata <= {24'h00_0000, aux_status};
                     end else if (avs_address == OFS_AUX_CFG) begin
                        avs_readdata <= {16'h0000, aux_inv, aux_en};
                     end else if (avs_address == OFS_PIN_CFG) begin
                        avs_readdata <= {18'h0_0000, def_four, def_two, pin_inv,
                                         pin_mode[3], pin_mode[2], pin_mode[1], pin_mode[0]};
                     end else begin
                        for (int i = 0; i < CHANNELS; i++) begin
                           if (avs_address == OFS_AUX_TIME + 8'(4 * i)) begin
                              avs_readdata <= {2'h0, hold[i], 2'h0, settle[i]};
                           end
                        end
                     end
                  end
               end
            end
            BUS_ANSWER: begin
               bus_state       <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state       <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   aux_enable_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ((aux_raw & ~aux_en) == 8'h00))
      else $error("disabled auxiliary input reached its filter");

   in_upper_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (avs_read && !avs_waitrequest && avs_address == OFS_IN_IMAGE) |-> (avs_readdata[31:4] == '0))
      else $error("input image upper bits not zero");

   mode_limit_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (pin_mode[0] != MODE_OUTPUT) && (pin_mode[2] != MODE_OUTPUT))
      else $error("output mode set on an input-only pin");

   drive_mode_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (pin_mode[PIN_TWO_IDX] != MODE_OUTPUT) |=> !discrete_pin_two_oe)
      else $error("pin two driven outside output mode");

   default_lvl_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!ctrl_active) |=> (discrete_pin_four_o == ($past(def_four) ^ $past(pin_inv[PIN_FOUR_IDX]))))
      else $error("pin four not at its default level without a controller");

   out_value_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && avs_address == OFS_OUT_IMAGE && avs_byteenable[0] && ctrl_active
       && !pin_inv[PIN_TWO_IDX]) ##1 (ctrl_active && !pin_inv[PIN_TWO_IDX])
      |=> (discrete_pin_two_o == $past(out_image[PIN_TWO_IDX])))
      else $error("pin two does not follow output image bit 1");

   bus_answer_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (bus_state == BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not given in one cycle");

   cfg_clear_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      cfg_wr |=> cfg_clear)
      else $error("configuration write did not clear the timers");

endmodule
`default_nettype wire

/* tb/dioc_field.sv */
// Field model: sensors on four pins, loads on pins two and four
`timescale 1ns/1ps
`default_nettype none
module dioc_field (
   // Sensor levels
   input  wire logic [3:0] sense,
   // Drive from the block
   input  wire logic       two_o,
   input  wire logic       two_oe,
   input  wire logic       four_o,
   input  wire logic       four_oe,
   // Pin levels
   output logic      [3:0] pin_in
);
   assign pin_in = {four_oe ? four_o : sense[3], sense[2], two_oe ? two_o : sense[1], sense[0]};
endmodule
`default_nettype wire

/* tb/dioc_top_tb.sv */
// Self-checking bench for the discrete input/output conditioner
`timescale 1ns/1ps
`default_nettype none
module dioc_top_tb;
   import dioc_pkg::*;
   logic        sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address, aux_in;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  sense, pin_in;
   logic        two_o, two_oe, four_o, four_oe;
   int          errors, n_compared, cycles;

   dioc_top #(.MS_CYCLES(8)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .aux_in(aux_in), .discrete_pin_in(pin_in),
      .discrete_pin_two_o(two_o), .discrete_pin_two_oe(two_oe),
      .discrete_pin_four_o(four_o), .discrete_pin_four_oe(four_oe));
   dioc_field u_field (.sense(sense), .two_o(two_o), .two_oe(two_oe), .four_o(four_o),
      .four_oe(four_oe), .pin_in(pin_in));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic give_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b1, a, 32'h0000_0000);
      chk(q, exp);
   endtask

   task automatic pins(input logic [3:0] exp);
      repeat (3) @(posedge sys_clk);
      chk(32'({two_oe, two_o, four_oe, four_o}), 32'(exp));
   endtask

   initial begin
      resetn = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      aux_in = 8'h00;
      sense = 4'h0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(OFS_PIN_CFG, 32'h0000_0055);
      rd(OFS_AUX_CFG, 32'h0000_0000);
      sense <= 4'hA;
      aux_in <= 8'hFF;
      repeat (6) @(posedge sys_clk);
      rd(OFS_IN_IMAGE, 32'h0000_000A);
      rd(OFS_AUX_STATUS, 32'h0000_0000);
      rd(8'hFC, 32'h0000_0000);
      wr(OFS_PIN_CFG, 32'h0000_0F55);
      repeat (6) @(posedge sys_clk);
      rd(OFS_IN_IMAGE, 32'h0000_0005);
      wr(OFS_PIN_CFG, 32'h0000_00AA);
      rd(OFS_PIN_CFG, 32'h0000_0099);
      pins(4'hA);
      wr(OFS_OUT_IMAGE, 32'h0000_00FF);
      pins(4'hA);
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_OUT_IMAGE, 32'h0000_0008);
      pins(4'hB);
      rd(OFS_IN_IMAGE, 32'h0000_0008);
      wr(OFS_OUT_IMAGE, 32'h0000_00F7);
      pins(4'hE);
      wr(OFS_PIN_CFG, 32'h0000_02AA);
      pins(4'hA);
      wr(OFS_CTRL, 32'h0000_0000);
      pins(4'hE);
      wr(OFS_PIN_CFG, 32'h0000_20AA);
      pins(4'hB);
      wr(OFS_AUX_CFG, 32'h0000_030F);
      aux_in <= 8'h05;
      repeat (6) @(posedge sys_clk);
      rd(OFS_AUX_STATUS, 32'h0000_0006);
      wr(OFS_AUX_TIME, 32'h0000_0002);
      aux_in <= 8'h04;
      rd(OFS_AUX_STATUS, 32'h0000_0006);
      repeat (40) @(posedge sys_clk);
      rd(OFS_AUX_STATUS, 32'h0000_0007);
      wr(OFS_AUX_TIME + 8'h04, 32'h0003_0000);
      aux_in <= 8'h06;
      repeat (20) @(posedge sys_clk);
      rd(OFS_AUX_STATUS, 32'h0000_0005);
      aux_in <= 8'h04;
      repeat (12) @(posedge sys_clk);
      aux_in <= 8'h06;
      rd(OFS_AUX_STATUS, 32'h0000_0007);
      repeat (40) @(posedge sys_clk);
      rd(OFS_AUX_STATUS, 32'h0000_0005);
      wr(OFS_PIN_CFG, 32'h0000_00A8);
      sense <= 4'hF;
      repeat (6) @(posedge sys_clk);
      rd(OFS_IN_IMAGE, 32'h0000_0004);
      wr(OFS_PIN_TIME + 8'h08, 32'h0000_0002);
      sense <= 4'hB;
      rd(OFS_IN_IMAGE, 32'h0000_0004);
      repeat (40) @(posedge sys_clk);
      rd(OFS_IN_IMAGE, 32'h0000_0000);
      give_verdict();
   end
endmodule
`default_nettype wire
